// File: include/stage_speed_defs.svh
`ifndef STAGE_SPEED_DEFS_SVH
`define STAGE_SPEED_DEFS_SVH

// ****************************************************************
// Clock and timing
// ****************************************************************
`define CLK_PERIOD_NS 8
`define DEBOUNCE_TIME_US 10000
`define DEBOUNCE_CYCLES ((`DEBOUNCE_TIME_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define TICK_TIME_US 100000
`define TICK_CYCLES ((`TICK_TIME_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define OFS_CTRL 12'h000
`define OFS_REPEAT 12'h004
`define OFS_DEAD 12'h008
`define OFS_BASE_FREQ 12'h00C
`define OFS_BASE_RAMP 12'h010
`define OFS_STATUS 12'h014
`define OFS_STAGE_BASE 4'h1
`define STAGE_SUB_FREQ 2'h0
`define STAGE_SUB_RAMP 2'h1
`define STAGE_SUB_RUN 2'h2
`define STAGE_SUB_WAIT 2'h3

// ****************************************************************
// Control field positions
// ****************************************************************
`define CTRL_SUBMODE_LSB 0
`define CTRL_RUNSRC_BIT 2
`define CTRL_KDIR_BIT 3
`define CTRL_LAST_LSB 4
`define CTRL_ENDACT_BIT 7
`define STAGE_DIR_BIT 16

// ****************************************************************
// Reset values and stage count
// ****************************************************************
`define RST_SUBMODE 2'h0
`define RST_LAST_STAGE 3'h7
`define RST_REPEAT 16'h0001
`define RST_DEAD 16'h0000
`define RST_WORD16 16'h0000
`define STAGE_COUNT 7

`endif

// File: include/stage_speed_pkg.sv
package stage_speed_pkg;

    // Stage-select sub-modes
    typedef enum logic [1:0] {
        SUB_SEVEN = 2'b00,
        SUB_AUTO = 2'b01,
        SUB_EIGHT = 2'b10,
        SUB_OTHER = 2'b11
    } submode_e;

    // Automatic cycling states
    typedef enum logic [2:0] {
        C_IDLE = 3'b000,
        C_RUN = 3'b001,
        C_WAIT = 3'b010,
        C_DEAD = 3'b011,
        C_HOLD = 3'b100
    } cyc_state_e;

    // Stored parameters of one speed stage
    typedef struct packed {
        logic [15:0] freq;
        logic [15:0] accel;
        logic [15:0] decel;
        logic [15:0] run_time;
        logic [15:0] wait_time;
        logic dir;
    } stage_s;

    // Command handed to the ramp generator
    typedef struct packed {
        logic run;
        logic dir;
        logic [15:0] freq;
        logic [15:0] accel;
        logic [15:0] decel;
    } drive_cmd_s;

endpackage

// File: design/contact_debounce.sv
`timescale 1ns/10ps
`default_nettype none
`include "stage_speed_defs.svh"

// Synchronises the three contacts, inverts them (closed = 1) and
// accepts a new code only after the inputs have differed from the accepted code for the hold time
module contact_debounce #(
    parameter int unsigned HOLD_CYCLES = `DEBOUNCE_CYCLES
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [2:0] contact_n,
    output logic [2:0] code
);

    logic [2:0] meta_r;
    logic [2:0] sync_r;
    logic [2:0] code_r;
    logic [20:0] cnt_r;
    logic [20:0] cnt_nxt;
    logic differ;

    // Closed contact pulls the pin low, so invert before use
    assign differ = (sync_r != code_r);
    assign cnt_nxt = differ ? cnt_r + 21'h000001 : 21'h000000;
    assign code = code_r;

    // ****************************************************************
    // Two-stage synchroniser and stability counter
    // ****************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_r <= 3'h0;
            sync_r <= 3'h0;
            code_r <= 3'h0;
            cnt_r <= 21'h000000;
        end else begin
            meta_r <= ~contact_n;
            sync_r <= meta_r;
            cnt_r <= cnt_nxt;
            if (differ && cnt_r >= 21'(HOLD_CYCLES - 1)) begin
                code_r <= sync_r;
                cnt_r <= 21'h000000;
            end
        end
    end

endmodule // contact_debounce

`default_nettype wire

// File: design/tick_timer.sv
`timescale 1ns/10ps
`default_nettype none
`include "stage_speed_defs.svh"

// Counts a loaded number of 0.1 s ticks and pulses expired once
module tick_timer #(
    parameter int unsigned TICK = `TICK_CYCLES
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic start,
    input wire logic abort,
    input wire logic [15:0] load,
    output logic expired
);

    logic busy_r;
    logic [23:0] pre_r;
    logic [15:0] left_r;
    logic expired_r;
    logic tick;

    assign tick = (pre_r == 24'(TICK - 1));
    assign expired = expired_r;

    // ****************************************************************
    // Prescaler and tick countdown
    // ****************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy_r <= 1'b0;
            pre_r <= 24'h000000;
            left_r <= 16'h0000;
            expired_r <= 1'b0;
        end else begin
            expired_r <= 1'b0;
            if (abort) begin
                busy_r <= 1'b0;
            end else if (start) begin
                busy_r <= 1'b1;
                pre_r <= 24'h000000;
                left_r <= load;
            end else if (busy_r) begin
                // A zero load expires at once rather than wrapping
                if (left_r == 16'h0000) begin
                    busy_r <= 1'b0;
                    expired_r <= 1'b1;
                end else if (tick) begin
                    pre_r <= 24'h000000;
                    left_r <= left_r - 16'h0001;
                end else begin
                    pre_r <= pre_r + 24'h000001;
                end
            end
        end
    end

endmodule // tick_timer

`default_nettype wire

// File: design/stage_speed_sequencer.sv
`timescale 1ns/10ps
`default_nettype none
`include "stage_speed_defs.svh"

// Function
// - Sub-mode value 0 seven-speed, 1 automatic cycling, 2 eight-speed.
// - Seven-speed: code 0 stops, codes 1 to 7 pick stored stages.
// - A contact closed to common return reads 1, open reads 0.
// - Stage sets ramps, frequency and direction; terminal source sets direction in manual modes.
// - Cycling runs each stage for its duration, then advances.
// - Cycling continues until stop or the repeat count is reached.
// - Cycling spans stage one to a configurable last stage, at most 7.
// - After the last cycle stop if end action is 0, else hold.
// - Cycling starts by run key or terminal, ends by stop or count.
// - Zero wait time moves straight to the next stage unless the direction changes.
// - Non-zero wait time stops, waits, then starts the next stage.
// - Direction change stops and applies the dead time first.
// - Eight-speed: code 0 uses base settings, codes 1 to 7 stages.
module stage_speed_sequencer
    import stage_speed_pkg::*;
#(
    parameter int unsigned HOLD_CYCLES = `DEBOUNCE_CYCLES,
    parameter int unsigned TICK = `TICK_CYCLES
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic prog_input_one_n,
    input wire logic prog_input_two_n,
    input wire logic prog_input_three_n,
    input wire logic keypad_run_key,
    input wire logic keypad_stop_key,
    input wire logic terminal_run,
    input wire logic terminal_stop,
    input wire logic forward_run_input,
    input wire logic reverse_run_input,
    output drive_cmd_s drive_cmd,
    output logic new_target
);

    // ****************************************************************
    // Helper functions
    // ****************************************************************
    // Keeps the last cycled stage within 2..7 and returns its index
    function automatic logic [2:0] last_index(input logic [2:0] v);
        if (v < 3'h2) begin
            return 3'h1;
        end
        return v - 3'h1;
    endfunction

    // Builds a running command from a stored stage
    function automatic drive_cmd_s from_stage(input stage_s s, input logic dir);
        drive_cmd_s c;
        c.run = 1'b1;
        c.dir = dir;
        c.freq = s.freq;
        c.accel = s.accel;
        c.decel = s.decel;
        return c;
    endfunction

    // ****************************************************************
    // Registers
    // ****************************************************************
    logic [1:0] submode_r;
    logic runsrc_r;
    logic kdir_r;
    logic [2:0] last_r;
    logic endact_r;
    logic [15:0] repeat_r;
    logic [15:0] dead_r;
    logic [15:0] base_freq_r;
    logic [15:0] base_accel_r;
    logic [15:0] base_decel_r;
    stage_s st_mem [0:`STAGE_COUNT-1];
    logic [31:0] prdata_r;
    logic pready_r;
    logic pslverr_r;
    drive_cmd_s drive_r;
    drive_cmd_s drive_nxt;
    logic new_target_r;
    cyc_state_e state_r;
    cyc_state_e state_nxt;
    logic [2:0] stage_r;
    logic [2:0] stage_nxt;
    logic [15:0] cycles_r;
    logic [15:0] cycles_nxt;
    logic man_run_r;
    logic [2:0] prev_code_r;
    logic run_prev_r;
    logic stop_prev_r;

    // ****************************************************************
    // APB decode
    // ****************************************************************
    logic setup;
    logic wr_en;
    logic stage_hit;
    logic [2:0] st_idx;
    logic [1:0] st_sub;
    logic hit;
    logic [31:0] rd_word;
    stage_s rd_st;

    assign setup = psel && !penable;
    assign wr_en = psel && penable && pready_r && pwrite && hit;
    assign st_idx = paddr[6:4];
    assign st_sub = paddr[3:2];
    assign stage_hit = (paddr[11:8] == `OFS_STAGE_BASE) && (paddr[7] == 1'b0)
                       && (st_idx != 3'h7) && (paddr[1:0] == 2'h0);
    assign hit = stage_hit || (paddr == `OFS_CTRL) || (paddr == `OFS_REPEAT)
                 || (paddr == `OFS_DEAD) || (paddr == `OFS_BASE_FREQ)
                 || (paddr == `OFS_BASE_RAMP) || (paddr == `OFS_STATUS);
    assign rd_st = st_mem[(st_idx == 3'h7) ? 3'h0 : st_idx];

    // Read multiplexer; unmapped addresses read as zero
    always_comb begin
        rd_word = 32'h00000000;
        if (stage_hit) begin
            case (st_sub)
                `STAGE_SUB_FREQ: rd_word = {16'h0000, rd_st.freq};
                `STAGE_SUB_RAMP: rd_word = {rd_st.decel, rd_st.accel};
                `STAGE_SUB_RUN: rd_word = {15'h0000, rd_st.dir, rd_st.run_time};
                default: rd_word = {16'h0000, rd_st.wait_time};
            endcase
        end else begin
            case (paddr)
                `OFS_CTRL: rd_word = {24'h000000, endact_r, last_r, kdir_r,
                                      runsrc_r, submode_r};
                `OFS_REPEAT: rd_word = {16'h0000, repeat_r};
                `OFS_DEAD: rd_word = {16'h0000, dead_r};
                `OFS_BASE_FREQ: rd_word = {16'h0000, base_freq_r};
                `OFS_BASE_RAMP: rd_word = {base_decel_r, base_accel_r};
                `OFS_STATUS: rd_word = {cycles_r, 7'h00, drive_r.dir,
                                        drive_r.run, 1'b0, state_r, stage_r};
                default: rd_word = 32'h00000000;
            endcase
        end
    end

    // ****************************************************************
    // Run and stop commands
    // ****************************************************************
    logic run_lvl;
    logic stop_lvl;
    logic run_cmd;
    logic stop_cmd;
    logic [2:0] code;
    logic term_dir;

    // Only the selected command source is obeyed
    assign run_lvl = runsrc_r ? terminal_run : keypad_run_key;
    assign stop_lvl = runsrc_r ? terminal_stop : keypad_stop_key;
    assign run_cmd = run_lvl && !run_prev_r && !stop_lvl;
    assign stop_cmd = stop_lvl && !stop_prev_r;
    assign term_dir = reverse_run_input && !forward_run_input;

    contact_debounce #(
        .HOLD_CYCLES(HOLD_CYCLES)
    ) u_debounce (
        .pclk(pclk),
        .presetn(presetn),
        .contact_n({prog_input_three_n, prog_input_two_n, prog_input_one_n}),
        .code(code)
    );

    // ****************************************************************
    // Automatic cycling
    // ****************************************************************
    stage_s cur_st;
    stage_s nxt_st;
    logic [2:0] last_idx;
    logic [2:0] next_idx;
    logic wrap;
    logic done_all;
    logic dir_flip;
    logic tmr_start;
    logic [15:0] tmr_load;
    logic tmr_expired;
    logic auto_mode;

    assign auto_mode = (submode_r == SUB_AUTO);
    assign cur_st = st_mem[stage_r];
    assign last_idx = last_index(last_r);
    assign wrap = (stage_r >= last_idx);
    assign next_idx = wrap ? 3'h0 : stage_r + 3'h1;
    assign nxt_st = st_mem[next_idx];
    // Repeat count zero means cycle without end
    assign done_all = wrap && (repeat_r != 16'h0000)
                      && (cycles_r + 16'h0001 >= repeat_r);
    assign dir_flip = (nxt_st.dir != cur_st.dir);

    tick_timer #(
        .TICK(TICK)
    ) u_timer (
        .pclk(pclk),
        .presetn(presetn),
        .start(tmr_start),
        .abort(stop_cmd || !auto_mode),
        .load(tmr_load),
        .expired(tmr_expired)
    );

    // Next state of the cycling sequence and its timer request
    always_comb begin
        state_nxt = state_r;
        stage_nxt = stage_r;
        cycles_nxt = cycles_r;
        tmr_start = 1'b0;
        tmr_load = 16'h0000;
        if (!auto_mode || stop_cmd) begin
            state_nxt = C_IDLE;
        end else begin
            case (state_r)
                C_IDLE: begin
                    if (run_cmd) begin
                        state_nxt = C_RUN;
                        stage_nxt = 3'h0;
                        cycles_nxt = 16'h0000;
                        tmr_start = 1'b1;
                        tmr_load = st_mem[0].run_time;
                    end
                end
                C_RUN: begin
                    if (tmr_expired) begin
                        if (wrap) begin
                            cycles_nxt = cycles_r + 16'h0001;
                        end
                        if (done_all) begin
                            state_nxt = endact_r ? C_HOLD : C_IDLE;
                        end else if (cur_st.wait_time != 16'h0000) begin
                            state_nxt = C_WAIT;
                            tmr_start = 1'b1;
                            tmr_load = cur_st.wait_time;
                        end else if (dir_flip) begin
                            state_nxt = C_DEAD;
                            tmr_start = 1'b1;
                            tmr_load = dead_r;
                        end else begin
                            state_nxt = C_RUN;
                            stage_nxt = next_idx;
                            tmr_start = 1'b1;
                            tmr_load = nxt_st.run_time;
                        end
                    end
                end
                C_WAIT: begin
                    if (tmr_expired && dir_flip) begin
                        state_nxt = C_DEAD;
                        tmr_start = 1'b1;
                        tmr_load = dead_r;
                    end else if (tmr_expired) begin
                        state_nxt = C_RUN;
                        stage_nxt = next_idx;
                        tmr_start = 1'b1;
                        tmr_load = nxt_st.run_time;
                    end
                end
                C_DEAD: begin
                    if (tmr_expired) begin
                        state_nxt = C_RUN;
                        stage_nxt = next_idx;
                        tmr_start = 1'b1;
                        tmr_load = nxt_st.run_time;
                    end
                end
                C_HOLD: state_nxt = C_HOLD;
                default: state_nxt = C_IDLE;
            endcase
        end
    end

    // ****************************************************************
    // Drive command selection
    // ****************************************************************
    stage_s code_st;
    logic stage_dir;

    assign code_st = st_mem[(code == 3'h0) ? 3'h0 : code - 3'h1];

    // Terminal control overrides the stored stage direction in seven- and eight-speed modes
    always_comb begin
        drive_nxt = '0;
        stage_dir = runsrc_r ? term_dir : code_st.dir;
        case (submode_r)
            SUB_SEVEN: begin
                if (man_run_r && code != 3'h0) begin
                    drive_nxt = from_stage(code_st, stage_dir);
                end
            end
            SUB_EIGHT: begin
                if (man_run_r && code == 3'h0) begin
                    drive_nxt.run = 1'b1;
                    drive_nxt.dir = runsrc_r ? term_dir : kdir_r;
                    drive_nxt.freq = base_freq_r;
                    drive_nxt.accel = base_accel_r;
                    drive_nxt.decel = base_decel_r;
                end else if (man_run_r) begin
                    drive_nxt = from_stage(code_st, stage_dir);
                end
            end
            SUB_AUTO: begin
                // Wait and dead time keep the output stopped
                if (state_r == C_RUN || state_r == C_HOLD) begin
                    drive_nxt = from_stage(cur_st, cur_st.dir);
                end
            end
            default: drive_nxt = '0;
        endcase
    end

    // ****************************************************************
    // Configuration registers and stage store
    // ****************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            submode_r <= `RST_SUBMODE;
            runsrc_r <= 1'b0;
            kdir_r <= 1'b0;
            last_r <= `RST_LAST_STAGE;
            endact_r <= 1'b0;
            repeat_r <= `RST_REPEAT;
            dead_r <= `RST_DEAD;
            base_freq_r <= `RST_WORD16;
            base_accel_r <= `RST_WORD16;
            base_decel_r <= `RST_WORD16;
            for (int i = 0; i < `STAGE_COUNT; i++) begin
                st_mem[i] <= '0;
            end
        end else if (wr_en && stage_hit) begin
            case (st_sub)
                `STAGE_SUB_FREQ: st_mem[st_idx].freq <= pwdata[15:0];
                `STAGE_SUB_RAMP: begin
                    st_mem[st_idx].accel <= pwdata[15:0];
                    st_mem[st_idx].decel <= pwdata[31:16];
                end
                `STAGE_SUB_RUN: begin
                    st_mem[st_idx].run_time <= pwdata[15:0];
                    st_mem[st_idx].dir <= pwdata[`STAGE_DIR_BIT];
                end
                default: st_mem[st_idx].wait_time <= pwdata[15:0];
            endcase
        end else if (wr_en) begin
            case (paddr)
                `OFS_CTRL: begin
                    submode_r <= pwdata[`CTRL_SUBMODE_LSB +: 2];
                    runsrc_r <= pwdata[`CTRL_RUNSRC_BIT];
                    kdir_r <= pwdata[`CTRL_KDIR_BIT];
                    last_r <= pwdata[`CTRL_LAST_LSB +: 3];
                    endact_r <= pwdata[`CTRL_ENDACT_BIT];
                end
                `OFS_REPEAT: repeat_r <= pwdata[15:0];
                `OFS_DEAD: dead_r <= pwdata[15:0];
                `OFS_BASE_FREQ: base_freq_r <= pwdata[15:0];
                `OFS_BASE_RAMP: begin
                    base_accel_r <= pwdata[15:0];
                    base_decel_r <= pwdata[31:16];
                end
                default: repeat_r <= repeat_r;
            endcase
        end
    end

    // ****************************************************************
    // Sequencer, bus answer and output flops
    // ****************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r <= 32'h00000000;
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            state_r <= C_IDLE;
            stage_r <= 3'h0;
            cycles_r <= 16'h0000;
            man_run_r <= 1'b0;
            run_prev_r <= 1'b0;
            stop_prev_r <= 1'b0;
            prev_code_r <= 3'h0;
            drive_r <= '0;
            new_target_r <= 1'b0;
        end else begin
            // No wait state: answer is ready in the first access cycle
            pready_r <= setup;
            pslverr_r <= setup && !hit;
            if (setup) begin
                prdata_r <= rd_word;
            end
            state_r <= state_nxt;
            stage_r <= stage_nxt;
            cycles_r <= cycles_nxt;
            run_prev_r <= run_lvl;
            stop_prev_r <= stop_lvl;
            if (stop_cmd) begin
                man_run_r <= 1'b0;
            end else if (run_cmd) begin
                man_run_r <= 1'b1;
            end
            prev_code_r <= code;
            drive_r <= drive_nxt;
            new_target_r <= (code != prev_code_r && !auto_mode)
                            || (stage_nxt != stage_r);
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign drive_cmd = drive_r;
    assign new_target = new_target_r;

endmodule // stage_speed_sequencer

`default_nettype wire

// File: testbench/seq_monitor.sv
`timescale 1ns/10ps
`default_nettype none
// ****
// Port checker
// ****
module seq_monitor
    import stage_speed_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [31:0] prdata,
    input wire logic keypad_stop_key,
    input wire drive_cmd_s drive_cmd,
    input wire logic new_target
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // A setup cycle is the first step of every bus transfer
    sequence setup_s; psel && !penable; endsequence
    sequence stop_held_s; keypad_stop_key [*3]; endsequence
    AST_ACK: assert property (setup_s |=> pready) else $error("no ready after setup");
    AST_READY_ACCESS: assert property (pready |-> psel && penable) else $error("stray ready");
    AST_READY_ONE: assert property (pready |=> !pready) else $error("ready held too long");
    AST_ERR_READY: assert property (pslverr |-> pready) else $error("error without ready");
    AST_ERR_ZERO: assert property (pslverr && !pwrite |-> prdata == 32'h0) else $error("bad rdata");
    AST_TGT_PULSE: assert property (new_target |=> !new_target) else $error("long pulse");
    AST_RESET_QUIET: assert property ($rose(presetn) |-> drive_cmd == '0) else $error("not quiet");
    AST_STOP_WINS: assert property (stop_held_s |=> !drive_cmd.run) else $error("run kept");
endmodule // seq_monitor

bind stage_speed_sequencer seq_monitor u_mon (.*);
`default_nettype wire

// File: testbench/switch_panel.sv
`timescale 1ns/10ps
`default_nettype none
// ****
// Contacts and keypad
// ****
module switch_panel (
    output logic one_n,
    output logic two_n,
    output logic three_n,
    output logic run_key,
    output logic stop_key,
    input wire logic pclk
);
    // Open contacts float high through their pull-ups
    initial {three_n, two_n, one_n, run_key, stop_key} = 5'h1C;
    task automatic set_code(input logic [2:0] c);
        @(posedge pclk);
        {three_n, two_n, one_n} <= ~c;
    endtask
    // Key held long enough to pass any edge detector, then settle time
    task automatic press(input logic stop);
        @(posedge pclk);
        if (stop) stop_key <= 1'b1;
        else run_key <= 1'b1;
        repeat (3) @(posedge pclk);
        {run_key, stop_key} <= 2'h0;
        repeat (3) @(posedge pclk);
    endtask
endmodule // switch_panel
`default_nettype wire

// File: testbench/test_stage_speed_sequencer.sv
`timescale 1ns/10ps
`default_nettype none
// ****
// Bench
// ****
module test_stage_speed_sequencer
    import stage_speed_pkg::*;
;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, er;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, o1, o2, o3, rk, sk, new_target;
    drive_cmd_s drive_cmd;
    logic tr = 1'b0, ts = 1'b0, fw = 1'b0, rv = 1'b0;
    int n_errors = 0, compares = 0, cyc = 0;
    always #4 pclk = ~pclk;
    switch_panel u_sw (.pclk(pclk), .one_n(o1), .two_n(o2), .three_n(o3),
        .run_key(rk), .stop_key(sk));
    // Short debounce and tick keep the run small
    stage_speed_sequencer #(.HOLD_CYCLES(4), .TICK(4)) u_dut (.pclk(pclk),
        .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .prog_input_one_n(o1), .prog_input_two_n(o2),
        .prog_input_three_n(o3), .keypad_run_key(rk), .keypad_stop_key(sk),
        .terminal_run(tr), .terminal_stop(ts), .forward_run_input(fw),
        .reverse_run_input(rv), .drive_cmd(drive_cmd), .new_target(new_target));
    task automatic end_sim();
        $display("errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            n_errors++;
            $display("CHECK FAILED %s exp %h got %h", n, e, g);
        end
    endtask
    // Request held from setup until pready is sampled high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        {psel, penable} <= 2'b00;
    endtask
    task automatic code(input logic [2:0] c);
        u_sw.set_code(c);
        repeat (30) if (new_target !== 1'b1) @(posedge pclk);
        chk("target", 32'h1, 32'(new_target));
    endtask
    task automatic t_seven();
        code(3'h3);
        u_sw.press(1'b0);
        chk("run", 32'h1, 32'(drive_cmd.run));
        chk("freq3", 32'h1002, 32'(drive_cmd.freq));
        code(3'h7);
        chk("freq7", 32'h1006, 32'(drive_cmd.freq));
        code(3'h0);
        chk("stop", 32'h0, 32'(drive_cmd.run));
        u_sw.press(1'b1);
        $display("seven done");
    endtask
    task automatic t_eight();
        apb(1'b1, 12'h000, 32'h72);
        code(3'h5);
        u_sw.press(1'b0);
        chk("freq5", 32'h1004, 32'(drive_cmd.freq));
        code(3'h0);
        chk("base", 32'hBA5, 32'(drive_cmd.freq));
        u_sw.press(1'b1);
        apb(1'b1, 12'h000, 32'h76);
        {tr, rv} <= 2'h3;
        repeat (4) @(posedge pclk);
        chk("tdir", 32'h1, 32'(drive_cmd.dir));
        ts <= 1'b1;
        repeat (4) @(posedge pclk);
        chk("tstop", 32'h0, 32'(drive_cmd.run));
        {tr, ts, rv} <= 3'h0;
        $display("eight done");
    endtask
    task automatic t_auto(input logic [31:0] ctl);
        logic s2, s3;
        s2 = 1'b0;
        s3 = 1'b0;
        apb(1'b1, 12'h000, ctl);
        u_sw.press(1'b0);
        repeat (150) begin
            @(posedge pclk);
            s2 |= drive_cmd.freq === 16'h1001;
            s3 |= drive_cmd.freq === 16'h1002;
        end
        chk("stage2", 32'h1, 32'(s2));
        chk("stage3", 32'h0, 32'(s3));
        chk("endrun", 32'(ctl[7]), 32'(drive_cmd.run));
        apb(1'b0, 12'h014, 32'h0);
        chk("count", 32'h1, 32'(rd[31:16]));
        u_sw.press(1'b1);
        chk("halt", 32'h0, 32'(drive_cmd.run));
        $display("auto done");
    endtask
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 5000) begin
            n_errors++;
            end_sim();
        end
    end
    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, 12'h000, 32'h0);
        chk("ctrl", 32'h70, rd);
        apb(1'b0, 12'hFFC, 32'h0);
        chk("unmapped", 32'h1, 32'(er));
        apb(1'b1, 12'h00C, 32'hBA5);
        for (int n = 0; n < 7; n++) begin
            apb(1'b1, 12'h100 + 12'(n * 16), 32'h1000 + 32'(n));
            apb(1'b1, 12'h108 + 12'(n * 16), 32'h1);
        end
        t_seven();
        t_eight();
        t_auto(32'h21);
        t_auto(32'hA1);
        end_sim();
    end
endmodule // test_stage_speed_sequencer
`default_nettype wire
